//--- core/ecrb_pkg.sv
// ==========================================================================
// shared constants of the extended configuration bank
package ecrb_pkg;

  localparam int           ECRB_DW        = 8;
  localparam int           ECRB_IW        = 6;
  localparam int           ECRB_NREG      = 9;
  localparam int           ECRB_NSTRAP    = 11;

  // index values on the data port
  localparam logic [5:0]   IDX_LOCK       = 6'h05;
  localparam logic [5:0]   IDX_GFX_MODE   = 6'h06;
  localparam logic [5:0]   IDX_EXT_CLK    = 6'h07;
  localparam logic [5:0]   IDX_THRESH_A   = 6'h08;
  localparam logic [5:0]   IDX_THRESH_B   = 6'h09;
  localparam logic [5:0]   IDX_OVERFLOW   = 6'h0A;
  localparam logic [5:0]   IDX_MISC_A     = 6'h0B;
  localparam logic [5:0]   IDX_MISC_B     = 6'h0C;
  localparam logic [5:0]   IDX_STRAP_A    = 6'h0D;
  localparam logic [5:0]   IDX_STRAP_B    = 6'h0E;
  localparam logic [5:0]   IDX_SCRATCH_A  = 6'h0F;
  localparam logic [5:0]   IDX_SCRATCH_B  = 6'h10;

  // storage slots for the writable bytes
  localparam logic [3:0]   SLOT_GFX_MODE  = 4'h0;
  localparam logic [3:0]   SLOT_EXT_CLK   = 4'h1;
  localparam logic [3:0]   SLOT_THRESH_A  = 4'h2;
  localparam logic [3:0]   SLOT_THRESH_B  = 4'h3;
  localparam logic [3:0]   SLOT_OVERFLOW  = 4'h4;
  localparam logic [3:0]   SLOT_MISC_A    = 4'h5;
  localparam logic [3:0]   SLOT_MISC_B    = 4'h6;
  localparam logic [3:0]   SLOT_SCRATCH_A = 4'h7;
  localparam logic [3:0]   SLOT_SCRATCH_B = 4'h8;
  localparam logic [3:0]   SLOT_NONE      = 4'hF;

  // values
  localparam logic [7:0]   UNLOCK_KEY     = 8'h86;
  localparam logic [7:0]   RESET_BYTE     = 8'h00;
  localparam logic [7:0]   ZERO_BYTE      = 8'h00;
  localparam logic [5:0]   RESET_INDEX    = 6'h00;
  localparam int           STRAP_SETTLE   = 16;

  // lock read-back states
  typedef enum logic [1:0] {LK_RESET, LK_OPEN, LK_SHUT} ecrb_lock_t;

endpackage

//--- core/ecrb_pin_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// three-flop input filter: a change counts once stages two and three agree
module ecrb_pin_sync
  import ecrb_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // pins and filtered value
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinStable
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end
    else
    begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pinStable <= '0;
    else if (stage2_q == stage3_q)
      pinStable <= stage3_q;
  end

endmodule

//--- core/ecrb_strap_latch.sv
`timescale 1ns/10ps
// ==========================================================================
// catches the filtered strap pins once, a settle time after reset release
module ecrb_strap_latch
  import ecrb_pkg::*;
#(
  parameter int W      = ECRB_NSTRAP,
  parameter int SETTLE = STRAP_SETTLE
)(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  // filtered straps in, latched straps out
  input  wire logic [W-1:0] strapStable,
  output logic      [W-1:0] strapHeld_q,
  output logic              strapDone_q
);

  logic [$clog2(SETTLE+1)-1:0] settleCnt_q;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      settleCnt_q <= '0;
    else if (!strapDone_q)
      settleCnt_q <= settleCnt_q + 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strapHeld_q <= '0;
      strapDone_q <= 1'b0;
    end
    else if (!strapDone_q && settleCnt_q == ($clog2(SETTLE+1))'(SETTLE))
    begin
      strapHeld_q <= strapStable;
      strapDone_q <= 1'b1;
    end
  end

endmodule

//--- core/ecrb_bank.sv
`timescale 1ns/10ps
// How it works
// [R1] index port holds a six-bit register select; top two bits read zero
// [R2] software writes the index, then the data port reaches that register
// [R3] writing the key to the lock byte unlocks and shows the open signature
// [R4] writing anything else locks and shows the shut signature
// [R5] locked bank ignores data writes except to the lock byte; reads change nothing
// [R6] mode byte holds eight graphics and text enables, one means enabled
// [R7] clock byte: DAC speed, external clock halving, four-bit clock choice
// [R8] first threshold byte: host low threshold high nibble, engine high low nibble
// [R9] second threshold byte: character fetch high nibble, host high low nibble
// [R10] overflow byte: offset bits 11..8 and four vertical bit-ten extensions
// [R11] misc A bit 7 picks colour byte order, zero red first
// [R12] misc A bits 6..5: off, A segment, or B segment for both upper codes
// [R13] misc A bits 4..0: modulation, dual segment, busy io, packed, transfer
// [R14] misc B: access widths, cache, strobe swap, test, memory size code
// [R15] misc B bit 0 enables synchronous reset of the display timing
// [R16] strap byte A high nibble shows four latched power-on straps
// [R17] strap byte A low nibble shows four more latched straps
// [R18] strap byte B low bits show the function number straps
// [R19] two scratch bytes, reset to zero, no hardware effect
module ecrb_bank
  import ecrb_pkg::*;
#(
  parameter logic [7:0] OPEN_SIG = 8'h5A, // arbitrary value
  parameter logic [7:0] SHUT_SIG = 8'hC3, // arbitrary value
  parameter int         SETTLE   = STRAP_SETTLE
)(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // host io access, dataSel low picks the index port
  input  wire logic       ioWrStb,
  input  wire logic       ioRdStb,
  input  wire logic       dataSel,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  output logic            ioRdValid,
  // strap pins
  input  wire logic       rom64kStrap,
  input  wire logic       internalClockStrap,
  input  wire logic       dacOffStrap,
  input  wire logic       multifunctionStrap,
  input  wire logic       strobeTypeStrap,
  input  wire logic       romDecodeOffStrap,
  input  wire logic       videoOffStrap,
  input  wire logic       portSelectStrap,
  input  wire logic [2:0] functionNumberStraps,
  // lock state
  output logic            extUnlocked,
  output logic            strapsLatched,
  // graphics mode
  output logic            linearAddrEn,
  output logic            hwCursorEn,
  output logic            interlaceEn,
  output logic            trueColourEn,
  output logic            colour64kEn,
  output logic            colour32kEn,
  output logic            enhGraphicsEn,
  output logic            enhTextEn,
  // external video clock
  output logic            dacHighSpeed,
  output logic            extClkDiv2,
  output logic      [3:0] extClkSel,
  // arbitration thresholds
  output logic      [3:0] hostLowThresh,
  output logic      [3:0] engineHighThresh,
  output logic      [3:0] charFetchThresh,
  output logic      [3:0] hostHighThresh,
  // timing overflow
  output logic      [3:0] screenOffsetHi,
  output logic            vRetraceStartB10,
  output logic            vBlankStartB10,
  output logic            vDispEndB10,
  output logic            vTotalB10,
  // misc control a
  output logic            bgrByteOrder,
  output logic            mmioEn,
  output logic            mmioSegB,
  output logic            frameRateModEn,
  output logic            dualSegmentEn,
  output logic            ioWhileBusyEn,
  output logic            packed16En,
  output logic            blockTransferEn,
  // misc control b
  output logic            mem32En,
  output logic            text16En,
  output logic            readAheadEn,
  output logic            columnStrobeSwap,
  output logic            testModeEn,
  output logic      [1:0] memConfig,
  output logic            syncTimingResetEn
);

  // ========================================================================
  // state
  logic [ECRB_IW-1:0]      index_q;
  ecrb_lock_t              lock_q;
  logic                    unlocked_q;
  logic [ECRB_DW-1:0]      regFile_q [ECRB_NREG];
  logic                    mmioEn_q;
  logic                    mmioSegB_q;
  logic [ECRB_NSTRAP-1:0]  strapPins;
  logic [ECRB_NSTRAP-1:0]  strapStable;
  logic [ECRB_NSTRAP-1:0]  strapHeld_q;
  logic                    strapDone_q;
  logic [3:0]              wrSlot;
  logic                    dataWr;
  logic                    regWr;
  logic [7:0]              rdData_d;
  logic [7:0]              ioRdData_q;
  logic                    ioRdValid_q;

  // ========================================================================
  // strap pins: filtered, then caught once
  assign strapPins = {rom64kStrap, internalClockStrap, dacOffStrap, multifunctionStrap,
                      strobeTypeStrap, romDecodeOffStrap, videoOffStrap, portSelectStrap,
                      functionNumberStraps};

  ecrb_pin_sync #(
    .W (ECRB_NSTRAP)
  ) u_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pinIn     (strapPins),
    .pinStable (strapStable)
  );

  ecrb_strap_latch #(
    .W      (ECRB_NSTRAP),
    .SETTLE (SETTLE)
  ) u_latch (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .strapStable (strapStable),
    .strapHeld_q (strapHeld_q),
    .strapDone_q (strapDone_q)
  );

  // ========================================================================
  // index decode
  function automatic logic [3:0] slotOf(input logic [5:0] idx);
    case (idx)
      IDX_GFX_MODE:  slotOf = SLOT_GFX_MODE;
      IDX_EXT_CLK:   slotOf = SLOT_EXT_CLK;
      IDX_THRESH_A:  slotOf = SLOT_THRESH_A;
      IDX_THRESH_B:  slotOf = SLOT_THRESH_B;
      IDX_OVERFLOW:  slotOf = SLOT_OVERFLOW;
      IDX_MISC_A:    slotOf = SLOT_MISC_A;
      IDX_MISC_B:    slotOf = SLOT_MISC_B;
      IDX_SCRATCH_A: slotOf = SLOT_SCRATCH_A;
      IDX_SCRATCH_B: slotOf = SLOT_SCRATCH_B;
      default:       slotOf = SLOT_NONE;
    endcase
  endfunction

  assign wrSlot = slotOf(index_q);
  assign dataWr = ioWrStb && dataSel;
  assign regWr  = dataWr && (lock_q == LK_OPEN) && (wrSlot != SLOT_NONE); // [R5]

  // ========================================================================
  // index port
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      index_q <= RESET_INDEX;
    else if (ioWrStb && !dataSel)
      index_q <= ioWrData[ECRB_IW-1:0]; // [R1] [R2]
  end

  // ========================================================================
  // lock byte
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_q     <= LK_RESET;
      unlocked_q <= 1'b0;
    end
    else if (dataWr && index_q == IDX_LOCK)
    begin
      unlocked_q <= (ioWrData == UNLOCK_KEY); // [R3] [R4]
      if (ioWrData == UNLOCK_KEY)
        lock_q <= LK_OPEN; // [R3]
      else
        lock_q <= LK_SHUT; // [R4]
    end
  end

  // ========================================================================
  // writable bytes, one flop group per slot
  genvar g;
  generate
    for (g = 0; g < ECRB_NREG; g++)
    begin : g_reg
      always_ff @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
          regFile_q[g] <= RESET_BYTE; // [R19]
        else if (regWr && wrSlot == 4'(g))
          regFile_q[g] <= ioWrData; // [R2] [R19]
      end
    end
  endgenerate

  // memory-mapped space decode kept in flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mmioEn_q   <= 1'b0;
      mmioSegB_q <= 1'b0;
    end
    else if (regWr && wrSlot == SLOT_MISC_A)
    begin
      mmioEn_q   <= |ioWrData[6:5]; // [R12]
      mmioSegB_q <= ioWrData[6]; // [R12]
    end
  end

  // ========================================================================
  // read path, answer one cycle after the strobe
  always_comb
  begin
    rdData_d = ZERO_BYTE;
    if (!dataSel)
      rdData_d = {2'b00, index_q}; // [R1]
    else
    begin
      case (index_q)
        IDX_LOCK:
        begin
          case (lock_q)
            LK_OPEN: rdData_d = OPEN_SIG; // [R3]
            LK_SHUT: rdData_d = SHUT_SIG; // [R4]
            default: rdData_d = RESET_BYTE;
          endcase
        end
        IDX_STRAP_A:   rdData_d = strapHeld_q[10:3]; // [R16] [R17]
        IDX_STRAP_B:   rdData_d = {5'h00, strapHeld_q[2:0]}; // [R18]
        default:
        begin
          if (wrSlot != SLOT_NONE)
            rdData_d = regFile_q[wrSlot];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ioRdData_q  <= ZERO_BYTE;
      ioRdValid_q <= 1'b0;
    end
    else
    begin
      ioRdValid_q <= ioRdStb;
      if (ioRdStb)
        ioRdData_q <= rdData_d; // [R2]
    end
  end

  // ========================================================================
  // outputs straight from the flops
  assign ioRdData          = ioRdData_q;
  assign ioRdValid         = ioRdValid_q;
  assign extUnlocked       = unlocked_q;
  assign strapsLatched     = strapDone_q;
  assign linearAddrEn      = regFile_q[SLOT_GFX_MODE][7]; // [R6]
  assign hwCursorEn        = regFile_q[SLOT_GFX_MODE][6]; // [R6]
  assign interlaceEn       = regFile_q[SLOT_GFX_MODE][5]; // [R6]
  assign trueColourEn      = regFile_q[SLOT_GFX_MODE][4]; // [R6]
  assign colour64kEn       = regFile_q[SLOT_GFX_MODE][3]; // [R6]
  assign colour32kEn       = regFile_q[SLOT_GFX_MODE][2]; // [R6]
  assign enhGraphicsEn     = regFile_q[SLOT_GFX_MODE][1]; // [R6]
  assign enhTextEn         = regFile_q[SLOT_GFX_MODE][0]; // [R6]
  assign dacHighSpeed      = regFile_q[SLOT_EXT_CLK][5]; // [R7]
  assign extClkDiv2        = regFile_q[SLOT_EXT_CLK][4]; // [R7]
  assign extClkSel         = regFile_q[SLOT_EXT_CLK][3:0]; // [R7]
  assign hostLowThresh     = regFile_q[SLOT_THRESH_A][7:4]; // [R8]
  assign engineHighThresh  = regFile_q[SLOT_THRESH_A][3:0]; // [R8]
  assign charFetchThresh   = regFile_q[SLOT_THRESH_B][7:4]; // [R9]
  assign hostHighThresh    = regFile_q[SLOT_THRESH_B][3:0]; // [R9]
  assign screenOffsetHi    = regFile_q[SLOT_OVERFLOW][7:4]; // [R10]
  assign vRetraceStartB10  = regFile_q[SLOT_OVERFLOW][3]; // [R10]
  assign vBlankStartB10    = regFile_q[SLOT_OVERFLOW][2]; // [R10]
  assign vDispEndB10       = regFile_q[SLOT_OVERFLOW][1]; // [R10]
  assign vTotalB10         = regFile_q[SLOT_OVERFLOW][0]; // [R10]
  assign bgrByteOrder      = regFile_q[SLOT_MISC_A][7]; // [R11]
  assign mmioEn            = mmioEn_q;
  assign mmioSegB          = mmioSegB_q;
  assign frameRateModEn    = regFile_q[SLOT_MISC_A][4]; // [R13]
  assign dualSegmentEn     = regFile_q[SLOT_MISC_A][3]; // [R13]
  assign ioWhileBusyEn     = regFile_q[SLOT_MISC_A][2]; // [R13]
  assign packed16En        = regFile_q[SLOT_MISC_A][1]; // [R13]
  assign blockTransferEn   = regFile_q[SLOT_MISC_A][0]; // [R13]
  assign mem32En           = regFile_q[SLOT_MISC_B][7]; // [R14]
  assign text16En          = regFile_q[SLOT_MISC_B][6]; // [R14]
  assign readAheadEn       = regFile_q[SLOT_MISC_B][5]; // [R14]
  assign columnStrobeSwap  = regFile_q[SLOT_MISC_B][4]; // [R14]
  assign testModeEn        = regFile_q[SLOT_MISC_B][3]; // [R14]
  assign memConfig         = regFile_q[SLOT_MISC_B][2:1]; // [R14]
  assign syncTimingResetEn = regFile_q[SLOT_MISC_B][0]; // [R15]

  // ========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_index_write: // [R1]
    assert property (ioWrStb && !dataSel ##1 ioRdStb && !dataSel
                     |=> ioRdData == {2'b00, $past(ioWrData[5:0], 2)})
    else $error("index read-back wrong");

  a_unlock_sig: // [R3]
    assert property (dataWr && index_q == IDX_LOCK && ioWrData == UNLOCK_KEY
                     ##1 ioRdStb && dataSel && index_q == IDX_LOCK |=> ioRdData == OPEN_SIG)
    else $error("unlock signature wrong");

  a_lock_sig: // [R4]
    assert property (dataWr && index_q == IDX_LOCK && ioWrData != UNLOCK_KEY
                     |=> (!extUnlocked and (ioRdStb && dataSel && index_q == IDX_LOCK
                     |=> ioRdData == SHUT_SIG)))
    else $error("lock signature wrong");

  a_locked_hold: // [R5]
    assert property (!extUnlocked && dataWr && index_q != IDX_LOCK
                     |=> $stable(linearAddrEn) && $stable(extClkSel) && $stable(memConfig))
    else $error("write took effect while locked");

  a_read_pure: // [R5]
    assert property (ioRdStb && !ioWrStb |=> $stable(index_q) && $stable(extUnlocked))
    else $error("read changed state");

  a_mode_write: // [R6]
    assert property (extUnlocked && dataWr && index_q == IDX_GFX_MODE
                     |=> {linearAddrEn, hwCursorEn, interlaceEn, trueColourEn,
                          colour64kEn, colour32kEn, enhGraphicsEn, enhTextEn}
                         == $past(ioWrData))
    else $error("mode byte not written");

  a_mmio_decode: // [R12]
    assert property (extUnlocked && dataWr && index_q == IDX_MISC_A
                     |=> mmioEn == ($past(ioWrData[6:5]) != 2'b00)
                         && mmioSegB == $past(ioWrData[6]))
    else $error("mmio decode wrong");

  a_strap_hold: // [R16]
    assert property (strapDone_q |=> $stable(strapHeld_q) [*4])
    else $error("strap value moved after latch");

  a_strap_b_read: // [R18]
    assert property (ioRdStb && dataSel && index_q == IDX_STRAP_B
                     |=> ioRdData[7:3] == 5'h00 && ioRdData[2:0] == strapHeld_q[2:0])
    else $error("strap b read wrong");

  a_scratch_keep: // [R19]
    assert property (extUnlocked && dataWr && index_q == IDX_SCRATCH_B
                     ##1 ioRdStb && dataSel && index_q == IDX_SCRATCH_B
                     |=> ioRdData == $past(ioWrData, 2))
    else $error("scratch byte lost");

endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
// ==========================================================================
// self-checking bench of the extended configuration bank
module tb;
  import ecrb_pkg::*;

  localparam logic [7:0] OPEN_SIG = 8'h4B; // arbitrary value
  localparam logic [7:0] SHUT_SIG = 8'hD2; // arbitrary value
  localparam int         SETTLE   = 4;
  localparam int         MAX_CYC  = 5000;

  // ==========================================================================
  // signals
  logic       clk_sys, arst_n, ioWrStb, ioRdStb, dataSel, ioRdValid, extUnlocked, strapsLatched;
  logic [7:0] ioWrData, ioRdData, strapA, rdVal, v;
  logic [2:0] fnStraps;
  logic       linearAddrEn, hwCursorEn, interlaceEn, trueColourEn, colour64kEn, colour32kEn;
  logic       enhGraphicsEn, enhTextEn, dacHighSpeed, extClkDiv2, vRetraceStartB10;
  logic       vBlankStartB10, vDispEndB10, vTotalB10, bgrByteOrder, mmioEn, mmioSegB;
  logic       frameRateModEn, dualSegmentEn, ioWhileBusyEn, packed16En, blockTransferEn;
  logic       mem32En, text16En, readAheadEn, columnStrobeSwap, testModeEn, syncTimingResetEn;
  logic [3:0] extClkSel, hostLowThresh, engineHighThresh, charFetchThresh, hostHighThresh;
  logic [3:0] screenOffsetHi;
  logic [1:0] memConfig;
  logic [5:0] idxTab [9];
  int         failCount, checks, cycles;

  // ==========================================================================
  // design under test
  ecrb_bank #(.OPEN_SIG(OPEN_SIG), .SHUT_SIG(SHUT_SIG), .SETTLE(SETTLE)) i_dut (
    .clk_sys, .arst_n, .ioWrStb, .ioRdStb, .dataSel, .ioWrData, .ioRdData, .ioRdValid,
    .rom64kStrap(strapA[7]), .internalClockStrap(strapA[6]), .dacOffStrap(strapA[5]),
    .multifunctionStrap(strapA[4]), .strobeTypeStrap(strapA[3]),
    .romDecodeOffStrap(strapA[2]), .videoOffStrap(strapA[1]), .portSelectStrap(strapA[0]),
    .functionNumberStraps(fnStraps), .extUnlocked, .strapsLatched,
    .linearAddrEn, .hwCursorEn, .interlaceEn, .trueColourEn, .colour64kEn, .colour32kEn,
    .enhGraphicsEn, .enhTextEn, .dacHighSpeed, .extClkDiv2, .extClkSel,
    .hostLowThresh, .engineHighThresh, .charFetchThresh, .hostHighThresh,
    .screenOffsetHi, .vRetraceStartB10, .vBlankStartB10, .vDispEndB10, .vTotalB10,
    .bgrByteOrder, .mmioEn, .mmioSegB, .frameRateModEn, .dualSegmentEn, .ioWhileBusyEn,
    .packed16En, .blockTransferEn, .mem32En, .text16En, .readAheadEn, .columnStrobeSwap,
    .testModeEn, .memConfig, .syncTimingResetEn
  );

  // ==========================================================================
  // clock and timeout
  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == MAX_CYC)
    begin
      failCount++;
      $display("[FAIL] run length expected below %0d seen %0d", MAX_CYC, cycles);
      endSim();
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic [7:0] fieldsOf(input logic [5:0] idx);
    case (idx)
      IDX_GFX_MODE: return {linearAddrEn, hwCursorEn, interlaceEn, trueColourEn,
                            colour64kEn, colour32kEn, enhGraphicsEn, enhTextEn};
      IDX_EXT_CLK:  return {2'b00, dacHighSpeed, extClkDiv2, extClkSel};
      IDX_THRESH_A: return {hostLowThresh, engineHighThresh};
      IDX_THRESH_B: return {charFetchThresh, hostHighThresh};
      IDX_OVERFLOW: return {screenOffsetHi, vRetraceStartB10, vBlankStartB10, vDispEndB10,
                            vTotalB10};
      IDX_MISC_A:   return {bgrByteOrder, mmioSegB, mmioEn, frameRateModEn, dualSegmentEn,
                            ioWhileBusyEn, packed16En, blockTransferEn};
      IDX_MISC_B:   return {mem32En, text16En, readAheadEn, columnStrobeSwap, testModeEn,
                            memConfig, syncTimingResetEn};
      default:      return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] expField(input logic [5:0] idx, input logic [7:0] d);
    case (idx)
      IDX_EXT_CLK:                  return {2'b00, d[5:0]};
      IDX_MISC_A:                   return {d[7], d[6], |d[6:5], d[4:0]};
      IDX_SCRATCH_A, IDX_SCRATCH_B: return 8'h00;
      default:                      return d;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge clk_sys);
    ioRdStb  = 1'b0;
    ioWrStb  = 1'b1;
    dataSel  = sel;
    ioWrData = d;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic sel);
    @(negedge clk_sys);
    ioWrStb = 1'b0;
    ioRdStb = 1'b1;
    dataSel = sel;
    @(posedge clk_sys);
    @(negedge clk_sys);
    ioRdStb = 1'b0;
    chk("read valid", 8'h01, {7'h00, ioRdValid});
    rdVal = ioRdData;
  endtask

  task automatic regWr(input logic [5:0] idx, input logic [7:0] d);
    wr(1'b0, {2'b00, idx});
    wr(1'b1, d);
    @(negedge clk_sys);
    ioWrStb = 1'b0;
  endtask

  task automatic regRd(input logic [5:0] idx);
    wr(1'b0, {2'b00, idx});
    rd(1'b1);
  endtask

  task automatic testDone(input string name);
    $display("test %s finished, checks so far %0d", name, checks);
  endtask

  task automatic resetCheck(input logic [7:0] sa, input logic [2:0] sb);
    @(negedge clk_sys);
    arst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("unlocked after reset", 8'h00, {7'h00, extUnlocked});
    for (int k = 0; k < 12 && strapsLatched !== 1'b1; k++) @(negedge clk_sys);
    chk("straps latched", 8'h01, {7'h00, strapsLatched});
    rd(1'b0);
    chk("index reset", 8'h00, rdVal);
    regRd(IDX_LOCK);
    chk("lock reset", 8'h00, rdVal);
    for (int i = 0; i < 9; i++)
    begin
      regRd(idxTab[i]);
      chk("register reset", 8'h00, rdVal);
      chk("field reset", 8'h00, fieldsOf(idxTab[i]));
    end
    regRd(IDX_STRAP_A);
    chk("strap byte a", sa, rdVal);
    chk("strap byte a low", {4'h0, sa[3:0]}, rdVal & 8'h0F);
    regRd(IDX_STRAP_B);
    chk("strap byte b", {5'h00, sb}, rdVal);
    testDone("reset");
  endtask

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    clk_sys   = 1'b0;
    arst_n    = 1'b0;
    ioWrStb   = 1'b0;
    ioRdStb   = 1'b0;
    dataSel   = 1'b0;
    ioWrData  = 8'h00;
    strapA    = 8'hA6;
    fnStraps  = 3'b101;
    failCount = 0;
    checks    = 0;
    cycles    = 0;
    idxTab    = '{IDX_GFX_MODE, IDX_EXT_CLK, IDX_THRESH_A, IDX_THRESH_B, IDX_OVERFLOW,
                  IDX_MISC_A, IDX_MISC_B, IDX_SCRATCH_A, IDX_SCRATCH_B};
    resetCheck(8'hA6, 3'b101);
    strapA   = 8'h00;
    fnStraps = 3'b000;
    regRd(IDX_STRAP_A);
    chk("strap a held", 8'hA6, rdVal);
    regRd(IDX_STRAP_B);
    chk("strap b held", 8'h05, rdVal);
    testDone("straps");
    regWr(IDX_GFX_MODE, 8'hFF);
    chk("locked mode fields", 8'h00, fieldsOf(IDX_GFX_MODE));
    regRd(IDX_GFX_MODE);
    chk("locked mode byte", 8'h00, rdVal);
    regWr(IDX_LOCK, 8'h85);
    regRd(IDX_LOCK);
    chk("shut signature", SHUT_SIG, rdVal);
    wr(1'b0, {2'b00, IDX_LOCK});
    wr(1'b1, UNLOCK_KEY);
    rd(1'b1);
    chk("unlocked flag", 8'h01, {7'h00, extUnlocked});
    chk("open signature", OPEN_SIG, rdVal);
    rd(1'b1);
    chk("open signature again", OPEN_SIG, rdVal);
    testDone("lock");
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        v = (p == 0 ? 8'hA5 : 8'h5A) ^ {2'b00, idxTab[i]};
        regWr(idxTab[i], idxTab[i] == IDX_EXT_CLK ? v & 8'h3F : v);
      end
      for (int i = 0; i < 9; i++)
      begin
        v = (p == 0 ? 8'hA5 : 8'h5A) ^ {2'b00, idxTab[i]};
        v = idxTab[i] == IDX_EXT_CLK ? v & 8'h3F : v;
        regRd(idxTab[i]);
        chk("register read back", v, rdVal);
        chk("register fields", expField(idxTab[i], v), fieldsOf(idxTab[i]));
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      regWr(IDX_MISC_A, {1'b0, 2'(k), 5'h00});
      chk("io space code", {6'h00, k != 0, k > 1}, {6'h00, mmioEn, mmioSegB});
    end
    wr(1'b0, {2'b00, IDX_SCRATCH_B});
    wr(1'b1, 8'hC3);
    rd(1'b1);
    chk("scratch back to back", 8'hC3, rdVal);
    testDone("bank");
    regWr(IDX_STRAP_A, 8'hFF);
    regRd(IDX_STRAP_A);
    chk("strap a read only", 8'hA6, rdVal);
    regWr(6'h11, 8'hFF);
    regRd(6'h11);
    chk("unmapped index", 8'h00, rdVal);
    wr(1'b0, 8'hFF);
    rd(1'b0);
    chk("index top bits", 8'h3F, rdVal);
    wr(1'b0, {2'b00, IDX_LOCK});
    wr(1'b1, 8'h00);
    rd(1'b1);
    chk("relock signature", SHUT_SIG, rdVal);
    chk("relocked flag", 8'h00, {7'h00, extUnlocked});
    regWr(IDX_SCRATCH_A, 8'hFF);
    regRd(IDX_SCRATCH_A);
    chk("locked scratch", 8'h5A ^ 8'h0F, rdVal);
    testDone("refusals");
    strapA   = 8'h59;
    fnStraps = 3'b010;
    resetCheck(8'h59, 3'b010);
    endSim();
  end

endmodule
